// >>> src/ccl_mst.sv
// Master end: line states for clean-group maintenance and the store after it
`timescale 1ns/100ps
`default_nettype none
`include "ccl_map.svh"

module ccl_mst #(
  parameter int ADDR_W = 32,
  parameter int IDX_W = 4,
  parameter int LINE_B = 6
) (
  input wire logic clk,
  input wire logic rst,
  ccl_link_if.mst lnk,
  input wire logic op_valid,
  input wire logic [1:0] op_code,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic op_shareable,
  output logic op_ready,
  output logic op_done,
  output logic op_err,
  output logic op_evicted,
  input wire logic st_valid,
  input wire logic st_full,
  input wire logic st_skip,
  output logic st_ready,
  input wire logic [ADDR_W-1:0] lk_addr,
  output ccl_pkg::ccl_line_t lk_state,
  output logic snp_dirty
);
  localparam int DEPTH = 1 << IDX_W;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (IDX_W < 1 || IDX_W + LINE_B > ADDR_W) begin : g_bad_idx
    $error("index does not fit address");
  end

  typedef enum {m_idle, m_wr_aw, m_wr_b, m_ar, m_r, m_store, m_ev_aw, m_ev_b} ccl_mst_st_t;

  function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = a[IDX_W+LINE_B-1:LINE_B];
  endfunction

  function automatic logic is_dirty(input ccl_pkg::ccl_line_t s);
    is_dirty = (s == ccl_pkg::ln_ud) || (s == ccl_pkg::ln_sd);
  endfunction

  // Legal end state for a start state and answer; bit 3 is the legal flag.
  // Only the expected end state is ever taken, never a looser alternative.
  function automatic logic [3:0] xlate(input logic [1:0] op, input ccl_pkg::ccl_line_t s,
                                       input logic [1:0] rs);
    xlate = {1'b0, ccl_pkg::ln_i};
    case (op)
      `CCL_OP_CU: begin
        if (rs == `CCL_RESP_UNIQ) begin
          case (s)
            ccl_pkg::ln_sc: xlate = {1'b1, ccl_pkg::ln_uc};
            ccl_pkg::ln_sd: xlate = {1'b1, ccl_pkg::ln_ud};
            default: xlate = {1'b1, s};
          endcase
        end
      end
      `CCL_OP_CS: begin
        if (s == ccl_pkg::ln_i && (rs == `CCL_RESP_UNIQ || rs == `CCL_RESP_SHRD)) begin
          xlate = {1'b1, ccl_pkg::ln_i};
        end else if (s == ccl_pkg::ln_uc && rs == `CCL_RESP_UNIQ) begin
          xlate = {1'b1, ccl_pkg::ln_uc};
        end else if (s == ccl_pkg::ln_sc && rs == `CCL_RESP_UNIQ) begin
          xlate = {1'b1, ccl_pkg::ln_uc};
        end else if (s == ccl_pkg::ln_sc && rs == `CCL_RESP_SHRD) begin
          xlate = {1'b1, ccl_pkg::ln_sc};
        end
      end
      `CCL_OP_CI: begin
        if (s == ccl_pkg::ln_i && rs == `CCL_RESP_UNIQ) begin
          xlate = {1'b1, ccl_pkg::ln_i};
        end
      end
      default: xlate = {1'b0, ccl_pkg::ln_i};
    endcase
  endfunction

  ccl_mst_st_t st_q, st_d;
  ccl_pkg::ccl_line_t lines_q [DEPTH];
  logic [1:0] op_q, aw_op_q;
  logic [ADDR_W-1:0] addr_q;
  logic ar_valid_q, aw_valid_q, r_ready_q, b_ready_q, ac_ready_q;
  logic op_ready_q, op_done_q, op_err_q, op_evicted_q, st_ready_q, snp_dirty_q, op_shareable_q;
  ccl_pkg::ccl_line_t lk_state_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire ac_hs = lnk.ac_valid && ac_ready_q;
  wire [IDX_W-1:0] ac_idx = idx_of(lnk.ac_addr);
  wire op_hs = op_valid && op_ready_q && !ac_hs;
  wire [IDX_W-1:0] new_idx = idx_of(op_addr);
  wire [IDX_W-1:0] idx_w = idx_of(addr_q);
  ccl_pkg::ccl_line_t new_line, cur_line;
  assign new_line = lines_q[new_idx];
  assign cur_line = lines_q[idx_w];
  wire bad_share = op_code == `CCL_OP_CU && !op_shareable;
  wire need_wc = op_code == `CCL_OP_CS && is_dirty(new_line);
  wire need_wb = op_code == `CCL_OP_CI && is_dirty(new_line);
  wire [3:0] xl = xlate(op_q, (ac_hs && ac_idx == idx_w) ? ccl_pkg::ln_i : cur_line, lnk.r_resp);
  wire r_hs = lnk.r_valid && r_ready_q;
  wire b_hs = lnk.b_valid && b_ready_q;
  wire st_hs = st_valid && st_ready_q;
  wire cur_unique = cur_line == ccl_pkg::ln_uc || cur_line == ccl_pkg::ln_ud;
  // An invalid line may only allocate through a full store
  wire st_alloc = st_full || (cur_unique && !st_skip);
  wire st_evict = !st_alloc && cur_line == ccl_pkg::ln_i;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      m_idle: begin
        if (op_hs && !bad_share) begin
          st_d = (need_wc || need_wb) ? m_wr_aw : m_ar;
        end
      end
      m_wr_aw: st_d = lnk.aw_ready ? m_wr_b : m_wr_aw;
      m_wr_b: st_d = b_hs ? m_ar : m_wr_b;
      m_ar: st_d = lnk.ar_ready ? m_r : m_ar;
      m_r: begin
        if (r_hs) begin
          st_d = (xl[3] && op_q == `CCL_OP_CU) ? m_store : m_idle;
        end
      end
      m_store: begin
        if (st_hs) begin
          st_d = st_evict ? m_ev_aw : m_idle;
        end
      end
      m_ev_aw: st_d = lnk.aw_ready ? m_ev_b : m_ev_aw;
      m_ev_b: st_d = b_hs ? m_idle : m_ev_b;
      default: st_d = m_idle;
    endcase
  end

  // ----------------------------------------------------------------
  // Line state table
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        lines_q[i] <= ccl_pkg::ln_i;
      end
    end else begin
      // Snoops are taken only while idle or waiting on an answer
      if (ac_hs) begin
        lines_q[ac_idx] <= ccl_pkg::ln_i;
      end
      if (op_hs && !bad_share && op_code == `CCL_OP_CI && !need_wb) begin
        lines_q[new_idx] <= ccl_pkg::ln_i;
      end
      if (st_q == m_wr_b && b_hs) begin
        if (aw_op_q == `CCL_AW_WB) begin
          lines_q[idx_w] <= ccl_pkg::ln_i;
        end else begin
          lines_q[idx_w] <= (cur_line == ccl_pkg::ln_sd) ? ccl_pkg::ln_sc
                                                          : ccl_pkg::ln_uc;
        end
      end
      if (r_hs && xl[3]) begin
        lines_q[idx_w] <= ccl_pkg::ccl_line_t'(xl[2:0]);
      end
      if (st_hs && st_alloc) begin
        lines_q[idx_w] <= ccl_pkg::ln_ud;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request registers and registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= m_idle;
      op_q <= 2'h0;
      aw_op_q <= 2'h0;
      addr_q <= '0;
      op_shareable_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (op_hs) begin
        op_q <= op_code;
        op_shareable_q <= op_shareable;
        addr_q <= op_addr;
        aw_op_q <= need_wb ? `CCL_AW_WB : `CCL_AW_WC;
      end
      if (st_hs && st_evict) begin
        aw_op_q <= `CCL_AW_EV;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ar_valid_q <= 1'b0;
      aw_valid_q <= 1'b0;
      r_ready_q <= 1'b0;
      b_ready_q <= 1'b0;
      ac_ready_q <= 1'b0;
      op_ready_q <= 1'b0;
      op_done_q <= 1'b0;
      op_err_q <= 1'b0;
      op_evicted_q <= 1'b0;
      st_ready_q <= 1'b0;
      snp_dirty_q <= 1'b0;
      lk_state_q <= ccl_pkg::ln_i;
    end else begin
      ar_valid_q <= st_d == m_ar;
      aw_valid_q <= st_d == m_wr_aw || st_d == m_ev_aw;
      r_ready_q <= st_d == m_r;
      b_ready_q <= st_d == m_wr_b || st_d == m_ev_b;
      // No snoop is let in between the unique answer and the store
      ac_ready_q <= st_d == m_idle || st_d == m_r;
      op_ready_q <= st_d == m_idle;
      st_ready_q <= st_d == m_store;
      op_err_q <= (op_hs && bad_share) || (r_hs && !xl[3]);
      op_done_q <= (op_hs && bad_share) || (r_hs && st_d == m_idle) ||
                   (st_hs && !st_evict) || (st_q == m_ev_b && b_hs);
      op_evicted_q <= st_q == m_ev_b && b_hs;
      snp_dirty_q <= ac_hs && is_dirty(lines_q[ac_idx]);
      lk_state_q <= lines_q[idx_of(lk_addr)];
    end
  end

  assign lnk.ar_valid = ar_valid_q;
  assign lnk.ar_addr = addr_q;
  assign lnk.ar_op = op_q;
  assign lnk.ar_share = op_shareable_q;
  assign lnk.aw_valid = aw_valid_q;
  assign lnk.aw_addr = addr_q;
  assign lnk.aw_op = aw_op_q;
  assign lnk.r_ready = r_ready_q;
  assign lnk.b_ready = b_ready_q;
  assign lnk.ac_ready = ac_ready_q;
  assign op_ready = op_ready_q;
  assign op_done = op_done_q;
  assign op_err = op_err_q;
  assign op_evicted = op_evicted_q;
  assign st_ready = st_ready_q;
  assign lk_state = lk_state_q;
  assign snp_dirty = snp_dirty_q;
endmodule

`default_nettype wire

// >>> pkg/ccl_map.svh
// Constants for the clean-group line state tracker and its link
`ifndef CCL_MAP_SVH
`define CCL_MAP_SVH

// ----------------------------------------------------------------
// Read address channel operation codes
// ----------------------------------------------------------------
`define CCL_OP_CU 2'h0
`define CCL_OP_CS 2'h1
`define CCL_OP_CI 2'h2

// ----------------------------------------------------------------
// Write address channel operation codes
// ----------------------------------------------------------------
`define CCL_AW_WB 2'h0
`define CCL_AW_WC 2'h1
`define CCL_AW_EV 2'h2

// ----------------------------------------------------------------
// Read response, bit 1 shared flag, bit 0 dirty handover
// ----------------------------------------------------------------
`define CCL_RESP_UNIQ 2'h0
`define CCL_RESP_SHRD 2'h2
`define CCL_RESP_IS 1
`define CCL_RESP_PD 0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CCL_CLK_PERIOD_NS 4
`define CCL_WORK_NS 20

`endif

// >>> pkg/ccl_pkg.sv
// Line state type used by the master end of the clean-group link and its bench
package ccl_pkg;

  typedef enum logic [2:0] {
    ln_i,
    ln_uc,
    ln_ud,
    ln_sc,
    ln_sd
  } ccl_line_t;

endpackage

// >>> pkg/ccl_link_if.sv
// Link between the caching master and the coherent interconnect
`timescale 1ns/100ps
`default_nettype none

interface ccl_link_if #(
  parameter int ADDR_W = 32
) (
  input wire logic clk
);
  logic ar_valid;
  logic ar_ready;
  logic [ADDR_W-1:0] ar_addr;
  logic [1:0] ar_op;
  logic ar_share;
  logic r_valid;
  logic r_ready;
  logic [1:0] r_resp;
  logic aw_valid;
  logic aw_ready;
  logic [ADDR_W-1:0] aw_addr;
  logic [1:0] aw_op;
  logic b_valid;
  logic b_ready;
  logic ac_valid;
  logic ac_ready;
  logic [ADDR_W-1:0] ac_addr;

  modport mst (
    output ar_valid, ar_addr, ar_op, ar_share, r_ready, aw_valid, aw_addr, aw_op,
    output b_ready, ac_ready,
    input ar_ready, r_valid, r_resp, aw_ready, b_valid, ac_valid, ac_addr
  );

  modport icn (
    input ar_valid, ar_addr, ar_op, ar_share, r_ready, aw_valid, aw_addr, aw_op,
    input b_ready, ac_ready,
    output ar_ready, r_valid, r_resp, aw_ready, b_valid, ac_valid, ac_addr
  );
endinterface

`default_nettype wire

// >>> src/ccl_icn.sv
// Interconnect end: answers clean-group requests and keeps a snoop filter
`timescale 1ns/100ps
`default_nettype none
`include "ccl_map.svh"

module ccl_icn #(
  parameter int ADDR_W = 32,
  parameter int IDX_W = 4,
  parameter int LINE_B = 6,
  parameter bit SNOOP_FILTER = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  ccl_link_if.icn lnk,
  input wire logic others_shared,
  input wire logic snp_valid,
  input wire logic [ADDR_W-1:0] snp_addr,
  output logic snp_ready,
  output logic snp_done,
  output logic [(1<<IDX_W)-1:0] sf_alloc
);
  localparam int DEPTH = 1 << IDX_W;
  localparam int WORK_CYC = (`CCL_WORK_NS + `CCL_CLK_PERIOD_NS - 1) / `CCL_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (WORK_CYC < 1 || WORK_CYC > 255) begin : g_bad_work
    $error("work time out of counter range");
  end
  if (IDX_W + LINE_B > ADDR_W) begin : g_bad_idx
    $error("index does not fit address");
  end

  typedef enum {i_idle, i_ar_acc, i_aw_acc, i_work, i_r, i_b, i_snp} ccl_icn_st_t;

  function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = a[IDX_W+LINE_B-1:LINE_B];
  endfunction

  ccl_icn_st_t st_q, st_d;
  logic [7:0] cnt_q;
  logic [1:0] op_q;
  logic [IDX_W-1:0] idx_q;
  logic [DEPTH-1:0] alloc_q;
  logic ar_ready_q, aw_ready_q, r_valid_q, b_valid_q, ac_valid_q;
  logic [1:0] r_resp_q;
  logic [ADDR_W-1:0] ac_addr_q;
  logic snp_ready_q, snp_done_q;

  wire ar_hs = lnk.ar_valid && ar_ready_q;
  wire aw_hs = lnk.aw_valid && aw_ready_q;
  wire r_hs = r_valid_q && lnk.r_ready;
  wire b_hs = b_valid_q && lnk.b_ready;
  wire ac_hs = ac_valid_q && lnk.ac_ready;
  wire snp_hs = snp_valid && snp_ready_q;
  wire snp_skip = SNOOP_FILTER && !alloc_q[idx_of(snp_addr)];
  wire work_done = cnt_q == 8'(WORK_CYC - 1);
  wire [1:0] resp_w = (op_q == `CCL_OP_CS) ? {others_shared, 1'b0}
                                           : `CCL_RESP_UNIQ;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      // A snoop already taken must be served even if a request arrived with it
      i_idle: begin
        if (snp_hs) begin
          st_d = snp_skip ? i_idle : i_snp;
        end else if (lnk.aw_valid) begin
          st_d = i_aw_acc;
        end else if (lnk.ar_valid) begin
          st_d = i_ar_acc;
        end
      end
      i_aw_acc: st_d = aw_hs ? i_b : i_aw_acc;
      i_ar_acc: st_d = ar_hs ? i_work : i_ar_acc;
      // Stands for cleaning and dropping the other copies before answering
      i_work: st_d = work_done ? i_r : i_work;
      i_r: st_d = r_hs ? i_idle : i_r;
      i_b: st_d = b_hs ? i_idle : i_b;
      i_snp: st_d = ac_hs ? i_idle : i_snp;
      default: st_d = i_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= i_idle;
      cnt_q <= 8'h00;
      op_q <= 2'h0;
      idx_q <= '0;
      r_resp_q <= 2'h0;
      ac_addr_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= (st_q == i_work) ? cnt_q + 8'h01 : 8'h00;
      if (ar_hs) begin
        op_q <= lnk.ar_op;
        idx_q <= idx_of(lnk.ar_addr);
      end
      if (aw_hs) begin
        op_q <= lnk.aw_op;
        idx_q <= idx_of(lnk.aw_addr);
      end
      if (st_q == i_work && work_done) begin
        r_resp_q <= resp_w;
      end
      if (snp_hs) begin
        ac_addr_q <= snp_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Snoop filter and registered link outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      alloc_q <= '0;
      ar_ready_q <= 1'b0;
      aw_ready_q <= 1'b0;
      r_valid_q <= 1'b0;
      b_valid_q <= 1'b0;
      ac_valid_q <= 1'b0;
      snp_ready_q <= 1'b0;
      snp_done_q <= 1'b0;
    end else begin
      if (r_hs && op_q == `CCL_OP_CU) begin
        alloc_q[idx_q] <= 1'b1;
      end
      if (b_hs && (op_q == `CCL_AW_WB || op_q == `CCL_AW_EV)) begin
        alloc_q[idx_q] <= 1'b0;
      end
      ar_ready_q <= st_d == i_ar_acc;
      aw_ready_q <= st_d == i_aw_acc;
      r_valid_q <= st_d == i_r;
      b_valid_q <= st_d == i_b;
      ac_valid_q <= st_d == i_snp;
      snp_ready_q <= st_d == i_idle && !lnk.aw_valid && !lnk.ar_valid && !snp_hs;
      snp_done_q <= ac_hs || (snp_hs && snp_skip && st_q == i_idle && st_d == i_idle);
    end
  end

  assign lnk.ar_ready = ar_ready_q;
  assign lnk.aw_ready = aw_ready_q;
  assign lnk.r_valid = r_valid_q;
  assign lnk.r_resp = r_resp_q;
  assign lnk.b_valid = b_valid_q;
  assign lnk.ac_valid = ac_valid_q;
  assign lnk.ac_addr = ac_addr_q;
  assign snp_ready = snp_ready_q;
  assign snp_done = snp_done_q;
  assign sf_alloc = alloc_q;
endmodule

`default_nettype wire

// >>> test/ccl_link_properties.sv
// Concurrent checks on the clean-group link between master and interconnect
`timescale 1ns/100ps
`default_nettype none
`include "ccl_map.svh"

module ccl_link_properties #(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ar_valid,
  input wire logic ar_ready,
  input wire logic [ADDR_W-1:0] ar_addr,
  input wire logic [1:0] ar_op,
  input wire logic ar_share,
  input wire logic r_valid,
  input wire logic r_ready,
  input wire logic [1:0] r_resp,
  input wire logic aw_valid,
  input wire logic [1:0] aw_op,
  input wire logic ac_valid,
  input wire logic ac_ready,
  input wire logic [ADDR_W-1:0] ac_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Operation awaiting its answer
  // ----------------------------------------------------------------
  // Reset value names no operation, so no answer check fires early
  logic [1:0] pend_op_q;
  logic [1:0] pend_op_d;
  assign pend_op_d = (ar_valid && ar_ready) ? ar_op : pend_op_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_op_q <= 2'h3;
    end else begin
      pend_op_q <= pend_op_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_clean_on_read: assert property (
    ar_valid |-> ar_op inside {`CCL_OP_CU, `CCL_OP_CS, `CCL_OP_CI})
    else $error("read address channel carries an unknown operation");
  a_unique_needs_share: assert property ((ar_valid && ar_op == `CCL_OP_CU) |-> ar_share)
    else $error("unique clean sent for a non-shareable address");
  a_request_held: assert property (
    (ar_valid && !ar_ready) |=> ar_valid && $stable(ar_addr) && $stable(ar_op))
    else $error("read request changed before its handshake");
  a_work_then_answer: assert property (
    (ar_valid && ar_ready) |=> !r_valid [*4] ##[1:60] r_valid)
    else $error("answer came too early or never");
  a_unique_answer: assert property (
    (r_valid && pend_op_q == `CCL_OP_CU) |-> r_resp == `CCL_RESP_UNIQ)
    else $error("unique clean answer is not unique and clean");
  a_shared_never_dirty: assert property (
    (r_valid && pend_op_q == `CCL_OP_CS) |-> !r_resp[`CCL_RESP_PD])
    else $error("shared clean answer passes dirtiness");
  a_inval_answer: assert property (
    (r_valid && pend_op_q == `CCL_OP_CI) |-> r_resp == 2'h0)
    else $error("clean-invalidate answer is not zero");
  a_answer_held: assert property ((r_valid && !r_ready) |=> r_valid && $stable(r_resp))
    else $error("answer changed before its handshake");
  a_snoop_after_store: assert property (
    (r_valid && r_ready && pend_op_q == `CCL_OP_CU) |-> ##2 !ac_ready)
    else $error("snoop accepted while the store is pending");
  a_write_ops_only: assert property (
    aw_valid |-> aw_op inside {`CCL_AW_WB, `CCL_AW_WC, `CCL_AW_EV})
    else $error("write address channel carries an unknown operation");
  a_snoop_held: assert property ((ac_valid && !ac_ready) |=> ac_valid && $stable(ac_addr))
    else $error("snoop changed before its handshake");
endmodule

`default_nettype wire

// >>> test/coherent_clean_txn_line_states_bench.sv
// Self-checking bench joining master and interconnect over the clean-group link
`timescale 1ns/100ps
`default_nettype none
`include "ccl_map.svh"

module coherent_clean_txn_line_states_bench;
  localparam logic [31:0] ADR_A = 32'h0000_0040;
  localparam logic [31:0] ADR_B = 32'h0000_0080;
  localparam logic [31:0] ADR_C = 32'h0000_00c0;
  logic clk;
  logic rst;
  logic op_valid;
  logic [1:0] op_code;
  logic [31:0] op_addr;
  logic op_shareable;
  logic op_ready;
  logic op_done;
  logic op_err;
  logic op_evicted;
  logic st_valid;
  logic st_full;
  logic st_skip;
  logic st_ready;
  logic [31:0] lk_addr;
  ccl_pkg::ccl_line_t lk_state;
  logic snp_dirty;
  logic others_shared;
  logic snp_valid;
  logic [31:0] snp_addr;
  logic snp_ready;
  logic snp_done;
  logic [15:0] sf_alloc;
  int bad_count;
  int n_compared;

  ccl_link_if lnk_if (.clk(clk));
  ccl_mst ccl_mst_i (.clk(clk), .rst(rst), .lnk(lnk_if), .op_valid(op_valid),
    .op_code(op_code), .op_addr(op_addr), .op_shareable(op_shareable), .op_ready(op_ready),
    .op_done(op_done), .op_err(op_err), .op_evicted(op_evicted), .st_valid(st_valid),
    .st_full(st_full), .st_skip(st_skip), .st_ready(st_ready), .lk_addr(lk_addr),
    .lk_state(lk_state), .snp_dirty(snp_dirty));
  ccl_icn ccl_icn_i (.clk(clk), .rst(rst), .lnk(lnk_if), .others_shared(others_shared),
    .snp_valid(snp_valid), .snp_addr(snp_addr), .snp_ready(snp_ready), .snp_done(snp_done),
    .sf_alloc(sf_alloc));
  ccl_link_properties #(.ADDR_W(32)) ccl_link_properties_i (.clk(clk), .rst(rst),
    .ar_valid(lnk_if.ar_valid), .ar_ready(lnk_if.ar_ready), .ar_addr(lnk_if.ar_addr),
    .ar_op(lnk_if.ar_op), .ar_share(lnk_if.ar_share), .r_valid(lnk_if.r_valid),
    .r_ready(lnk_if.r_ready), .r_resp(lnk_if.r_resp), .aw_valid(lnk_if.aw_valid),
    .aw_op(lnk_if.aw_op), .ac_valid(lnk_if.ac_valid), .ac_ready(lnk_if.ac_ready),
    .ac_addr(lnk_if.ac_addr));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic line_is(input string nm, input logic [31:0] a, input ccl_pkg::ccl_line_t e);
    @(posedge clk);
    lk_addr <= a;
    repeat (2) @(negedge clk);
    chk(nm, 4'(e), 4'(lk_state));
  endtask

  // Store mode md: 0 full line, 1 partial, 2 no store; hold delays the store
  task automatic do_op(input logic [1:0] c, input logic [31:0] a, input logic sh,
                       input int md, input int hold, output logic e, output logic v);
    int ph;
    e = 1'bx;
    v = 1'bx;
    ph = 0;
    @(posedge clk);
    op_code <= c;
    op_addr <= a;
    op_shareable <= sh;
    op_valid <= 1'b1;
    for (int n = 0; n < 400; n++) begin
      @(negedge clk);
      if (op_done) begin
        e = op_err;
        v = op_evicted;
        break;
      end
      if (op_valid && op_ready) begin
        @(posedge clk);
        op_valid <= 1'b0;
      end else if (st_ready && ph == 1) begin
        @(posedge clk);
        st_valid <= 1'b0;
        ph = 2;
      end else if (st_ready && ph == 0) begin
        if (hold > 0) begin
          hold--;
        end else begin
          @(posedge clk);
          st_valid <= 1'b1;
          st_full <= (md == 0);
          st_skip <= (md == 2);
          ph = 1;
        end
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_unique_clean();
    logic e;
    logic v;
    do_op(`CCL_OP_CU, ADR_A, 1'b0, 2, 0, e, v);
    chk("refused err", 4'h1, {3'h0, e});
    line_is("a after refusal", ADR_A, ccl_pkg::ln_i);
    do_op(`CCL_OP_CU, ADR_A, 1'b1, 1, 0, e, v);
    chk("partial evict", 4'h1, {3'h0, v});
    line_is("a after partial", ADR_A, ccl_pkg::ln_i);
    chk("filter a", 4'h0, {3'h0, sf_alloc[1]});
    do_op(`CCL_OP_CU, ADR_A, 1'b1, 2, 0, e, v);
    chk("skip evict", 4'h1, {3'h0, v});
    line_is("a after skip", ADR_A, ccl_pkg::ln_i);
    do_op(`CCL_OP_CU, ADR_B, 1'b1, 0, 0, e, v);
    chk("full evict", 4'h0, {3'h0, v});
    line_is("b after full", ADR_B, ccl_pkg::ln_ud);
    chk("filter b", 4'h1, {3'h0, sf_alloc[2]});
    do_op(`CCL_OP_CU, ADR_B, 1'b1, 0, 0, e, v);
    line_is("b dirty kept", ADR_B, ccl_pkg::ln_ud);
  endtask

  task automatic t_shared_clean();
    logic e;
    logic v;
    @(posedge clk);
    others_shared <= 1'b0;
    do_op(`CCL_OP_CS, ADR_B, 1'b1, 0, 0, e, v);
    chk("cs dirty err", 4'h0, {3'h0, e});
    line_is("b cleaned", ADR_B, ccl_pkg::ln_uc);
    do_op(`CCL_OP_CS, ADR_A, 1'b0, 0, 0, e, v);
    chk("cs non-shareable", 4'h0, {3'h0, e});
    line_is("a unique answer", ADR_A, ccl_pkg::ln_i);
    @(posedge clk);
    others_shared <= 1'b1;
    do_op(`CCL_OP_CS, ADR_A, 1'b1, 0, 0, e, v);
    line_is("a shared answer", ADR_A, ccl_pkg::ln_i);
    do_op(`CCL_OP_CS, ADR_B, 1'b1, 0, 0, e, v);
    chk("unique shared err", 4'h1, {3'h0, e});
    line_is("b unchanged", ADR_B, ccl_pkg::ln_uc);
  endtask

  task automatic t_clean_invalid();
    logic e;
    logic v;
    do_op(`CCL_OP_CI, ADR_B, 1'b1, 0, 0, e, v);
    line_is("b clean dropped", ADR_B, ccl_pkg::ln_i);
    do_op(`CCL_OP_CU, ADR_B, 1'b1, 0, 0, e, v);
    do_op(`CCL_OP_CI, ADR_B, 1'b1, 0, 0, e, v);
    chk("ci dirty err", 4'h0, {3'h0, e});
    line_is("b dirty dropped", ADR_B, ccl_pkg::ln_i);
    chk("filter b freed", 4'h0, {3'h0, sf_alloc[2]});
  endtask

  // A snoop to the line lands while the store is held back on purpose
  task automatic t_snoop_waits();
    logic e;
    logic v;
    fork
      do_op(`CCL_OP_CU, ADR_C, 1'b1, 0, 8, e, v);
      begin
        @(negedge clk iff st_ready);
        chk("filter c", 4'h1, {3'h0, sf_alloc[3]});
        @(posedge clk);
        snp_addr <= ADR_C;
        snp_valid <= 1'b1;
        @(negedge clk iff snp_ready);
        @(posedge clk);
        snp_valid <= 1'b0;
        for (int n = 0; n < 100 && !snp_done; n++) @(negedge clk);
        chk("snoop done", 4'h1, {3'h0, snp_done});
        chk("snoop dirty", 4'h1, {3'h0, snp_dirty});
        chk("store first", 4'h0, {3'h0, st_ready});
      end
    join
    line_is("c snooped", ADR_C, ccl_pkg::ln_i);
    // Line a was evicted, so the filter answers without probing the master
    @(posedge clk);
    snp_addr <= ADR_A;
    snp_valid <= 1'b1;
    @(negedge clk iff snp_ready);
    @(posedge clk);
    snp_valid <= 1'b0;
    @(negedge clk);
    chk("filtered snoop", 4'h1, {3'h0, snp_done});
    chk("filtered no probe", 4'h0, {3'h0, lnk_if.ac_valid});
  endtask

  // ----------------------------------------------------------------
  // Run
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    {op_valid, op_code, op_addr, op_shareable} = '0;
    {st_valid, st_full, st_skip, lk_addr} = '0;
    {others_shared, snp_valid, snp_addr} = '0;
    bad_count = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_unique_clean();
    t_shared_clean();
    t_clean_invalid();
    t_snoop_waits();
    give_verdict();
  end
endmodule

`default_nettype wire
